// ---- rtl/sgp_pkg.sv ----
package sgp_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [31:0] PIN_ENABLE_OFS    = 32'h01B00000;
  localparam logic [31:0] PIN_DIRECTION_OFS = 32'h01B00004;
  localparam logic [31:0] PIN_VALUE_OFS     = 32'h01B00008;
  localparam logic [31:0] HIGH_DELTA_OFS    = 32'h01B00010;
  localparam logic [31:0] HIGH_MASK_OFS     = 32'h01B00014;
  localparam logic [31:0] LOW_DELTA_OFS     = 32'h01B00018;
  localparam logic [31:0] LOW_MASK_OFS      = 32'h01B0001C;
  localparam logic [31:0] GLOBAL_CONTROL_OFS = 32'h01B00020;
  localparam logic [31:0] POLARITY_OFS      = 32'h01B00024;

  // ***************************************************************
  // Reset values and fields
  // ***************************************************************
  localparam int          PIN_COUNT          = 16;
  localparam logic [15:0] PIN_ENABLE_RESET   = 16'h00F9;
  localparam logic [15:0] PIN_DIRECTION_RESET = 16'h0000;
  localparam logic [15:0] ZERO16             = 16'h0000;
  localparam int          GC_EVENT_MODE_LSB  = 0;
  localparam logic [1:0]  GC_EVENT_MODE_RESET = 2'h0;

  // ***************************************************************
  // Event generation modes
  // ***************************************************************
  typedef enum logic [1:0] {
    SGP_MODE_PASS = 2'b00,
    SGP_MODE_ANY  = 2'b01,
    SGP_MODE_ALL  = 2'b10,
    SGP_MODE_OFF  = 2'b11
  } sgp_mode_t;

endpackage

// ---- rtl/sgp_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module sgp_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/sgp_gpio.sv ----
// Overview of operation
// - Pin acts as GPIO only when enabled.
// - Direction bit: 0 input, 1 output.
// - Direction matters only for enabled pins.
// - Enabled output drives last written value.
// - Enabled input reads sampled pin level.
// - Pin activity raises interrupt and DMA events.
// - Sixteen pins; bit x controls pin x.
// - Direction bits reset to zero.
// - Enable resets: bits 7..3 and 0 set.
`timescale 1ns/100ps
`default_nettype none
module sgp_gpio #(
  parameter int PINS = sgp_pkg::PIN_COUNT
) (
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  input  wire logic            cfg_req,
  input  wire logic            cfg_rnw,
  input  wire logic [31:0]     cfg_addr,
  input  wire logic [31:0]     cfg_wdata,
  output var  logic [31:0]     cfg_rdata,
  output var  logic            cfg_ack,
  input  wire logic [PINS-1:0] general_pins_in,
  output var  logic [PINS-1:0] general_pins_out,
  output var  logic [PINS-1:0] general_pins_oe,
  output var  logic            cpu_interrupt,
  output var  logic            dma_event
);

  // ***************************************************************
  // Storage
  // ***************************************************************
  logic [PINS-1:0] pin_enable_reg;
  logic [PINS-1:0] pin_direction_reg;
  logic [PINS-1:0] pin_value_reg;
  logic [PINS-1:0] high_delta_reg;
  logic [PINS-1:0] high_mask_reg;
  logic [PINS-1:0] low_delta_reg;
  logic [PINS-1:0] low_mask_reg;
  logic [PINS-1:0] interrupt_polarity_reg;
  logic [1:0]      global_control_reg;
  logic [2:0]      warmup;
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] pin_prev;
  logic [PINS-1:0] rise;
  logic [PINS-1:0] fall;
  logic [PINS-1:0] in_pins;
  logic [PINS-1:0] next_high_delta;
  logic [PINS-1:0] next_low_delta;
  logic [PINS-1:0] hits;
  logic            wr;
  logic            next_event;
  logic [31:0]     next_rdata;
  sgp_pkg::sgp_mode_t mode;

  sgp_sync #(.WIDTH(PINS)) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (general_pins_in),
    .sync_out (pin_sync)
  );

  assign wr      = cfg_req && !cfg_rnw;
  assign mode    = sgp_pkg::sgp_mode_t'(global_control_reg);
  assign in_pins = pin_enable_reg & ~pin_direction_reg;

  // ***************************************************************
  // Configuration registers
  // ***************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_enable_reg         <= sgp_pkg::PIN_ENABLE_RESET;
      pin_direction_reg      <= sgp_pkg::PIN_DIRECTION_RESET;
      pin_value_reg          <= sgp_pkg::ZERO16;
      high_mask_reg          <= sgp_pkg::ZERO16;
      low_mask_reg           <= sgp_pkg::ZERO16;
      interrupt_polarity_reg <= sgp_pkg::ZERO16;
      global_control_reg     <= sgp_pkg::GC_EVENT_MODE_RESET;
    end else if (wr) begin
      case (cfg_addr)
        sgp_pkg::PIN_ENABLE_OFS: pin_enable_reg <= cfg_wdata[15:0];
        sgp_pkg::PIN_DIRECTION_OFS: pin_direction_reg <= cfg_wdata[15:0];
        sgp_pkg::PIN_VALUE_OFS: pin_value_reg <= cfg_wdata[15:0];
        sgp_pkg::HIGH_MASK_OFS:     high_mask_reg <= cfg_wdata[15:0];
        sgp_pkg::LOW_MASK_OFS:      low_mask_reg <= cfg_wdata[15:0];
        sgp_pkg::POLARITY_OFS:      interrupt_polarity_reg <= cfg_wdata[15:0];
        sgp_pkg::GLOBAL_CONTROL_OFS: begin
          global_control_reg <= cfg_wdata[sgp_pkg::GC_EVENT_MODE_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
  end

  // ***************************************************************
  // Transition capture
  // ***************************************************************
  // Polarity inverts the sense so the same delta logic serves both edges.
  // Capture waits until the synchroniser and the previous-level flop hold
  // real pin levels, so a pin that is high at reset is not taken as an edge.
  assign rise = {PINS{warmup[2]}} & in_pins
                & (pin_sync ^ interrupt_polarity_reg)
                & ~(pin_prev ^ interrupt_polarity_reg);
  assign fall = {PINS{warmup[2]}} & in_pins
                & ~(pin_sync ^ interrupt_polarity_reg)
                & (pin_prev ^ interrupt_polarity_reg);

  // Writing one clears a delta bit, but a fresh edge in the same cycle wins.
  always_comb begin
    next_high_delta = high_delta_reg;
    next_low_delta  = low_delta_reg;
    if (wr && cfg_addr == sgp_pkg::HIGH_DELTA_OFS) begin
      next_high_delta = high_delta_reg & ~cfg_wdata[15:0];
    end
    if (wr && cfg_addr == sgp_pkg::LOW_DELTA_OFS) begin
      next_low_delta = low_delta_reg & ~cfg_wdata[15:0];
    end
    next_high_delta = next_high_delta | rise;
    next_low_delta  = next_low_delta | fall;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      warmup         <= 3'h0;
      pin_prev       <= sgp_pkg::ZERO16;
      high_delta_reg <= sgp_pkg::ZERO16;
      low_delta_reg  <= sgp_pkg::ZERO16;
    end else begin
      warmup         <= {warmup[1:0], 1'b1};
      pin_prev       <= pin_sync;
      high_delta_reg <= next_high_delta;
      low_delta_reg  <= next_low_delta;
    end
  end

  // ***************************************************************
  // Event generation
  // ***************************************************************
  assign hits = (high_delta_reg & high_mask_reg)
                | (low_delta_reg & low_mask_reg);

  always_comb begin
    case (mode)
      sgp_pkg::SGP_MODE_PASS: next_event = |(in_pins & pin_sync
                                 & (high_mask_reg | low_mask_reg));
      sgp_pkg::SGP_MODE_ANY:  next_event = |hits;
      sgp_pkg::SGP_MODE_ALL:  next_event = ((high_mask_reg | low_mask_reg)
                                 != sgp_pkg::ZERO16)
                                 && ((hits | ~(high_mask_reg | low_mask_reg))
                                 == {PINS{1'b1}});
      default:                next_event = 1'b0;
    endcase
  end

  // Events are levels held while the causing condition stands.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_interrupt <= 1'b0;
      dma_event     <= 1'b0;
    end else begin
      cpu_interrupt <= next_event;
      dma_event     <= next_event;
    end
  end

  // ***************************************************************
  // Pins
  // ***************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      general_pins_out <= sgp_pkg::ZERO16;
      general_pins_oe  <= sgp_pkg::ZERO16;
    end else begin
      general_pins_out <= pin_value_reg;
      general_pins_oe  <= pin_enable_reg & pin_direction_reg;
    end
  end

  // ***************************************************************
  // Read path
  // ***************************************************************
  // Enabled input pins read back their sampled level; all other pins the written value.
  always_comb begin
    next_rdata = 32'h00000000;
    case (cfg_addr)
      sgp_pkg::PIN_ENABLE_OFS:     next_rdata[15:0] = pin_enable_reg;
      sgp_pkg::PIN_DIRECTION_OFS:  next_rdata[15:0] = pin_direction_reg;
      sgp_pkg::PIN_VALUE_OFS:      next_rdata[15:0] = (in_pins & pin_sync)
                                      | (~in_pins & pin_value_reg);
      sgp_pkg::HIGH_DELTA_OFS:     next_rdata[15:0] = high_delta_reg;
      sgp_pkg::HIGH_MASK_OFS:      next_rdata[15:0] = high_mask_reg;
      sgp_pkg::LOW_DELTA_OFS:      next_rdata[15:0] = low_delta_reg;
      sgp_pkg::LOW_MASK_OFS:       next_rdata[15:0] = low_mask_reg;
      sgp_pkg::GLOBAL_CONTROL_OFS: next_rdata[1:0]  = global_control_reg;
      sgp_pkg::POLARITY_OFS:       next_rdata[15:0] = interrupt_polarity_reg;
      default:                     next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata <= 32'h00000000;
      cfg_ack   <= 1'b0;
    end else begin
      cfg_ack   <= cfg_req;
      cfg_rdata <= (cfg_req && cfg_rnw) ? next_rdata : 32'h00000000;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence s_enable_write;
    cfg_req && !cfg_rnw && cfg_addr == sgp_pkg::PIN_ENABLE_OFS;
  endsequence

  sequence s_enable_read;
    cfg_req && cfg_rnw && cfg_addr == sgp_pkg::PIN_ENABLE_OFS;
  endsequence

  a_disabled_pin_quiet: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    $rose(general_pins_oe[0]) |-> $past(pin_enable_reg[0]))
    else $error("Output enabled on a disabled pin.");

  a_dir_drives_oe: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    general_pins_oe == $past(pin_enable_reg & pin_direction_reg))
    else $error("Output enable does not follow direction.");

  a_dir_needs_enable: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (general_pins_oe & ~$past(pin_enable_reg)) == 16'h0000)
    else $error("Direction acted without enable.");

  a_value_to_pin: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    cfg_req && !cfg_rnw && cfg_addr == sgp_pkg::PIN_VALUE_OFS
    |-> ##2 general_pins_out == $past(cfg_wdata[15:0], 2))
    else $error("Pin does not show written value.");

  a_input_readback: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    cfg_req && cfg_rnw && cfg_addr == sgp_pkg::PIN_VALUE_OFS
    |=> (cfg_rdata[15:0] & $past(in_pins))
        == ($past(pin_sync) & $past(in_pins)))
    else $error("Input read does not match pin level.");

  a_event_any_mode: assert property (@(posedge core_clk)
    disable iff (!reset_n) mode == sgp_pkg::SGP_MODE_ANY && |hits
    |=> cpu_interrupt && dma_event)
    else $error("Masked transition raised no event.");

  // A write followed by a read back shows only the low half was stored.
  a_enable_upper_zero: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    s_enable_write ##1 s_enable_read
    |=> cfg_rdata == {16'h0000, $past(cfg_wdata[15:0], 2)})
    else $error("Reserved enable bits not ignored.");

  a_rise_latched: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    |rise |=> (high_delta_reg & $past(rise)) == $past(rise))
    else $error("Transition not latched.");

endmodule
`default_nettype wire

// ---- testbench/sgp_pin_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
module sgp_pin_partner (
  input  wire logic        core_clk,
  input  wire logic [15:0] pins_out,
  input  wire logic [15:0] pins_oe,
  input  wire logic [15:0] ext_level,
  input  wire logic [15:0] ext_drive,
  output var  logic [15:0] pins_in
);
  // ***************************************************************
  // Wire resolution
  // ***************************************************************
  logic [15:0] float_pat;
  initial float_pat = 16'hA5A5;
  // A pin nobody drives wanders, so no design can lean on its last level.
  always @(posedge core_clk) float_pat <= ~float_pat;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pins_oe[i])
        pins_in[i] = pins_out[i];
      else
        pins_in[i] = ext_drive[i] ? ext_level[i] : float_pat[i];
    end
  end
endmodule
`default_nettype wire

// ---- testbench/test_sgp_gpio.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_sgp_gpio;
  logic core_clk, reset_n, cfg_req, cfg_rnw, cfg_ack;
  logic cpu_interrupt, dma_event;
  logic [31:0] cfg_addr, cfg_wdata, cfg_rdata, cycles;
  int seed;
  logic [15:0] pins_in, pins_out, pins_oe, ext_level, ext_drive;
  logic [15:0] en, dir, val, lvl;
  logic [32:0] notes[$];
  logic [32:0] note;
  int failures, num_checks;

  sgp_gpio uut (.core_clk(core_clk), .reset_n(reset_n), .cfg_req(cfg_req),
    .cfg_rnw(cfg_rnw), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .general_pins_in(pins_in),
    .general_pins_out(pins_out), .general_pins_oe(pins_oe),
    .cpu_interrupt(cpu_interrupt), .dma_event(dma_event));
  sgp_pin_partner far (.core_clk(core_clk), .pins_out(pins_out),
    .pins_oe(pins_oe), .ext_level(ext_level), .ext_drive(ext_drive),
    .pins_in(pins_in));

  // ***************************************************************
  // Checking and bus access
  // ***************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks=%0d mismatches=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Request stays high between accesses so back-to-back cycles are legal.
  task acc(input logic rnw, input logic [31:0] a, d, e);
    notes.push_back({rnw, e});
    cfg_req = 1'b1;
    cfg_rnw = rnw;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge core_clk);
    #1;
  endtask
  task idle(input int n);
    cfg_req = 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 32'h1;
    if (cycles == 32'h4E20) begin
      failures++;
      final_report;
    end
  end
  always @(posedge core_clk) begin
    if (cfg_ack === 1'b1) begin
      if (notes.size() == 0) chk(32'h1, 32'h0);
      else begin
        note = notes.pop_front();
        if (note[32]) chk(cfg_rdata, note[31:0]);
      end
    end
  end

  initial begin
    seed = 32'h1949F5C3;
    cycles = 32'h0;
    {reset_n, cfg_req, cfg_rnw, cfg_addr, cfg_wdata} = '0;
    ext_level = 16'h0000;
    ext_drive = 16'hFFFF;
    repeat (12) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    acc(1'b1, sgp_pkg::PIN_ENABLE_OFS, 32'h0, 32'h000000F9);
    acc(1'b1, sgp_pkg::PIN_DIRECTION_OFS, 32'h0, 32'h0);
    acc(1'b1, 32'h01B0000C, 32'h0, 32'h0);
    acc(1'b0, sgp_pkg::PIN_ENABLE_OFS, 32'hFFFFFFFF, 32'h0);
    acc(1'b1, sgp_pkg::PIN_ENABLE_OFS, 32'h0, 32'h0000FFFF);
    idle(2);
    chk({16'h0, pins_oe}, 32'h0);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) begin
      en = 16'($random(seed));
      dir = 16'($random(seed));
      val = 16'($random(seed));
      lvl = 16'($random(seed));
      ext_level = lvl;
      acc(1'b0, sgp_pkg::PIN_ENABLE_OFS, {16'hFFFF, en}, 32'h0);
      acc(1'b0, sgp_pkg::PIN_DIRECTION_OFS, {16'hFFFF, dir}, 32'h0);
      acc(1'b0, sgp_pkg::PIN_VALUE_OFS, {16'h0, val}, 32'h0);
      idle(4);
      chk({16'h0, pins_oe}, {16'h0, en & dir});
      chk({16'h0, pins_out & en & dir}, {16'h0, val & en & dir});
      acc(1'b1, sgp_pkg::PIN_VALUE_OFS, 32'h0,
          {16'h0, (lvl & en & ~dir) | (val & ~(en & ~dir))});
      acc(1'b1, sgp_pkg::PIN_DIRECTION_OFS, 32'h0, {16'h0, dir});
      idle(1);
    end
    $display("test pin_roles done");
    ext_level = 16'h0000;
    acc(1'b0, sgp_pkg::PIN_ENABLE_OFS, 32'h1, 32'h0);
    acc(1'b0, sgp_pkg::PIN_DIRECTION_OFS, 32'h0, 32'h0);
    acc(1'b0, sgp_pkg::HIGH_MASK_OFS, 32'h1, 32'h0);
    acc(1'b0, sgp_pkg::LOW_MASK_OFS, 32'h1, 32'h0);
    acc(1'b0, sgp_pkg::GLOBAL_CONTROL_OFS, {30'h0, sgp_pkg::SGP_MODE_PASS},
        32'h0);
    idle(5);
    chk({31'h0, cpu_interrupt}, 32'h0);
    ext_level = 16'h0001;
    idle(6);
    chk({31'h0, cpu_interrupt}, 32'h1);
    chk({31'h0, dma_event}, 32'h1);
    acc(1'b0, sgp_pkg::PIN_ENABLE_OFS, 32'h0, 32'h0);
    idle(5);
    chk({31'h0, cpu_interrupt}, 32'h0);
    acc(1'b0, sgp_pkg::PIN_ENABLE_OFS, 32'h1, 32'h0);
    acc(1'b0, sgp_pkg::GLOBAL_CONTROL_OFS, {30'h0, sgp_pkg::SGP_MODE_OFF},
        32'h0);
    idle(5);
    chk({31'h0, dma_event}, 32'h0);
    $display("test events done");
    acc(1'b0, sgp_pkg::HIGH_DELTA_OFS, 32'hFFFF, 32'h0);
    acc(1'b0, sgp_pkg::LOW_DELTA_OFS, 32'hFFFF, 32'h0);
    acc(1'b0, sgp_pkg::GLOBAL_CONTROL_OFS, {30'h0, sgp_pkg::SGP_MODE_ANY},
        32'h0);
    acc(1'b1, sgp_pkg::HIGH_DELTA_OFS, 32'h0, 32'h0);
    idle(3);
    chk({31'h0, cpu_interrupt}, 32'h0);
    ext_level = 16'h0000;
    idle(6);
    chk({31'h0, cpu_interrupt}, 32'h1);
    chk({31'h0, dma_event}, 32'h1);
    acc(1'b1, sgp_pkg::LOW_DELTA_OFS, 32'h0, 32'h1);
    acc(1'b1, sgp_pkg::HIGH_DELTA_OFS, 32'h0, 32'h0);
    acc(1'b0, sgp_pkg::LOW_DELTA_OFS, 32'h1, 32'h0);
    idle(3);
    chk({31'h0, cpu_interrupt}, 32'h0);
    // With polarity set, a rising pin lands in the low delta register.
    acc(1'b0, sgp_pkg::POLARITY_OFS, 32'h1, 32'h0);
    idle(2);
    ext_level = 16'h0001;
    idle(6);
    acc(1'b1, sgp_pkg::LOW_DELTA_OFS, 32'h0, 32'h1);
    acc(1'b1, sgp_pkg::HIGH_DELTA_OFS, 32'h0, 32'h0);
    acc(1'b0, sgp_pkg::GLOBAL_CONTROL_OFS, {30'h0, sgp_pkg::SGP_MODE_ALL},
        32'h0);
    idle(3);
    chk({31'h0, cpu_interrupt}, 32'h1);
    acc(1'b0, sgp_pkg::HIGH_MASK_OFS, 32'h3, 32'h0);
    idle(3);
    chk({31'h0, cpu_interrupt}, 32'h0);
    $display("test deltas done");
    // Pins stand high across a second reset; no edge may be seen after it.
    ext_level = 16'h00F9;
    idle(6);
    reset_n = 1'b0;
    idle(3);
    reset_n = 1'b1;
    idle(5);
    chk({16'h0, pins_oe}, 32'h0);
    chk({31'h0, cpu_interrupt}, 32'h0);
    acc(1'b1, sgp_pkg::HIGH_DELTA_OFS, 32'h0, 32'h0);
    acc(1'b1, sgp_pkg::LOW_DELTA_OFS, 32'h0, 32'h0);
    acc(1'b1, sgp_pkg::PIN_ENABLE_OFS, 32'h0, 32'h000000F9);
    acc(1'b1, sgp_pkg::PIN_DIRECTION_OFS, 32'h0, 32'h0);
    idle(2);
    $display("test mid_reset done");
    chk({31'h0, notes.size() == 0}, 32'h1);
    final_report;
  end
endmodule
`default_nettype wire
